//--- stm_timer.sv
// Purpose: Standard 10-bit timer with compare output, timer and PWM modes
// Assumes: Single clock; external count clock pin synchronised here
// Notes: Capture and single-pulse modes are not built
// Summary of operation
// - Counter readable as low and high bytes
// - Unused high bits read as zero
// - Compare value A is read/write ten bits
// - Mode field; 00 is compare output mode
// - Clear-select low: period or overflow clears
// - Clear-select high: compare A clears, no period flag
// - Pin moves only on compare A match and on run rising edge
// - Action field sets, clears, toggles or holds pin
// - Run rising edge loads initial pin level
// - Mode 11 is compare mode without pin
// - PWM swap bit picks period and duty sources
// - PWM ignores clear-select bit
// - PWM raises both flags on matches
// - PWM level, action forcing and inversion
// - PWM counting continues when pin is forced
// - Period codes give multiples of 128 steps in PWM, one step more in compare modes; zero gives 1024
// - Duty at or above period gives full duty
// - Run rising clears counter; low keeps value
// - Period compares counter bits nine to seven
// - Pause bit freezes counter, resumes on clear
module stm_timer
  import stm_pkg::*;
#(
  parameter int CNT_W = STM_CNT_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic base_tick,
  input wire logic count_clk_pin,
  output logic timer_output_pin,
  output logic timer_output_pin_en,
  output logic irq_req
);

  stm_state_t s_r;
  stm_state_t s_nxt;
  stm_bus_req_t req;

  logic [1:0] mode;
  logic [1:0] act;
  logic [2:0] per;
  logic run;
  logic pause;
  logic tick;
  logic cmp_a_hit;
  logic per_hit;
  logic ovf_hit;
  logic clr_a;
  logic period_end;
  logic [CNT_W-1:0] cnt_plus;
  logic [CNT_W:0] period_len;
  logic [CNT_W:0] duty_len;
  logic pwm_active;
  logic pwm_level;
  logic [7:0] rd_mux;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign mode = s_r.ctrl1[STM_C1_MODE +: 2];
  assign act = s_r.ctrl1[STM_C1_ACT +: 2];
  assign per = s_r.ctrl0[STM_C0_PER +: 3];
  assign run = s_r.ctrl0[STM_C0_RUN];
  assign pause = s_r.ctrl0[STM_C0_PAUSE];
  assign cnt_plus = s_r.cnt + 1'b1;

  // Count clock selection
  always_comb begin
    case (s_r.ctrl0[STM_C0_CKSEL +: 3])
      STM_CK_DIV4: tick = (s_r.presc[1:0] == 2'h3);
      STM_CK_SYS: tick = 1'b1;
      STM_CK_DIV16: tick = (s_r.presc[3:0] == 4'hF);
      STM_CK_DIV64: tick = (s_r.presc == 6'h3F);
      STM_CK_BASE: tick = base_tick;
      STM_CK_PIN_R: tick = s_r.ck_s2 & ~s_r.ck_d;
      STM_CK_PIN_F: tick = ~s_r.ck_s2 & s_r.ck_d;
      default: tick = 1'b0;
    endcase
  end

  // Comparators
  always_comb begin
    cmp_a_hit = (s_r.cnt == s_r.cmpa);
    per_hit = (per != 3'h0) && (s_r.cnt[CNT_W-1 -: 3] == per);
    ovf_hit = (per == 3'h0) && (s_r.cnt == '1);
    // Period length in counter clocks
    period_len = (per == 3'h0) ? (CNT_W+1)'(1 << CNT_W)
                               : (CNT_W+1)'({per, 7'h00});
    duty_len = {1'b0, s_r.cmpa};
    if (s_r.ctrl1[STM_C1_SWAP]) begin
      period_len = (s_r.cmpa == '0) ? (CNT_W+1)'(1 << CNT_W) : {1'b0, s_r.cmpa};
      duty_len = (per == 3'h0) ? (CNT_W+1)'(1 << CNT_W) : (CNT_W+1)'({per, 7'h00});
    end
    pwm_active = ({1'b0, s_r.cnt} < duty_len) || (duty_len >= period_len);
  end

  // Clearing source per mode
  always_comb begin
    clr_a = 1'b0;
    period_end = 1'b0;
    if (mode == STM_MODE_PWM) begin
      if (s_r.ctrl1[STM_C1_SWAP]) begin
        period_end = ({1'b0, cnt_plus} == period_len) || (s_r.cnt == '1);
      end else begin
        period_end = ({1'b0, cnt_plus} == period_len) || (s_r.cnt == '1);
      end
    end else if (s_r.ctrl1[STM_C1_CLRSEL]) begin
      clr_a = cmp_a_hit;
    end else begin
      period_end = per_hit || ovf_hit;
    end
  end

  // PWM pin level
  always_comb begin
    case (act)
      STM_ACT_NONE: pwm_level = ~s_r.ctrl1[STM_C1_INIT];
      STM_ACT_LOW: pwm_level = s_r.ctrl1[STM_C1_INIT];
      default: pwm_level = pwm_active ? s_r.ctrl1[STM_C1_INIT]
                                      : ~s_r.ctrl1[STM_C1_INIT];
    endcase
  end

  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = STM_RST_BYTE;
    s_nxt.presc = s_r.presc + 6'h01;
    s_nxt.ck_s1 = count_clk_pin;
    s_nxt.ck_s2 = s_r.ck_s1;
    s_nxt.ck_d = s_r.ck_s2;
    s_nxt.run_d = run;

    // Counting
    if (run && !s_r.run_d) begin
      s_nxt.cnt = '0;
      if (mode != STM_MODE_PWM) begin
        s_nxt.pin = s_r.ctrl1[STM_C1_INIT];
      end
    end else if (run && !pause && tick) begin
      if (mode == STM_MODE_PWM) begin
        // Clearing source flags its own comparator
        if (s_r.ctrl1[STM_C1_SWAP] ? period_end : cmp_a_hit) begin
          s_nxt.flag_a = 1'b1;
        end
        if (s_r.ctrl1[STM_C1_SWAP] ? (per_hit && s_r.cnt[6:0] == 7'h00) : period_end) begin
          s_nxt.flag_p = 1'b1;
        end
        s_nxt.cnt = period_end ? '0 : cnt_plus;
      end else if (mode != STM_MODE_CAP) begin
        if (cmp_a_hit) begin
          s_nxt.flag_a = 1'b1;
          if (mode == STM_MODE_CMP) begin
            case (act)
              STM_ACT_LOW: s_nxt.pin = 1'b0;
              STM_ACT_HIGH: s_nxt.pin = 1'b1;
              STM_ACT_TOG: s_nxt.pin = ~s_r.pin;
              default: s_nxt.pin = s_r.pin;
            endcase
          end
        end
        if (!s_r.ctrl1[STM_C1_CLRSEL] && (per_hit || ovf_hit)) begin
          s_nxt.flag_p = 1'b1;
        end
        s_nxt.cnt = (period_end || clr_a) ? '0 : cnt_plus;
      end
    end
    // stopped counter keeps its residual value by default

    // Register writes
    if (req.wr && req.addr[7:3] == 5'h00) begin
      case (req.addr[2:0])
        STM_ADDR_CTRL0: s_nxt.ctrl0 = req.wdata;
        STM_ADDR_CTRL1: s_nxt.ctrl1 = req.wdata;
        STM_ADDR_CMPA_LO: s_nxt.cmpa[7:0] = req.wdata;
        STM_ADDR_CMPA_HI: s_nxt.cmpa[CNT_W-1:8] = req.wdata[CNT_W-9:0];
        STM_ADDR_FLAGS: begin
          // Write one to clear; a same-cycle event wins only if the flag was clear
          if (req.wdata[STM_FL_A] && !(s_nxt.flag_a && !s_r.flag_a)) begin
            s_nxt.flag_a = 1'b0;
          end
          if (req.wdata[STM_FL_P] && !(s_nxt.flag_p && !s_r.flag_p)) begin
            s_nxt.flag_p = 1'b0;
          end
          s_nxt.en_a = req.wdata[STM_FL_AEN];
          s_nxt.en_p = req.wdata[STM_FL_PEN];
        end
        default: begin
        end
      endcase
    end

    if (req.rd) begin
      s_nxt.rdata = rd_mux;
    end
  end

  // Read decode
  always_comb begin
    rd_mux = STM_RST_BYTE;
    if (req.addr[7:3] == 5'h00) begin
      case (req.addr[2:0])
        STM_ADDR_CTRL0: rd_mux = s_r.ctrl0;
        STM_ADDR_CTRL1: rd_mux = s_r.ctrl1;
        STM_ADDR_CNT_LO: rd_mux = s_r.cnt[7:0];
        STM_ADDR_CNT_HI: rd_mux = {6'h00, s_r.cnt[CNT_W-1:8]};
        STM_ADDR_CMPA_LO: rd_mux = s_r.cmpa[7:0];
        STM_ADDR_CMPA_HI: rd_mux = {6'h00, s_r.cmpa[CNT_W-1:8]};
        STM_ADDR_FLAGS: rd_mux = {4'h0, s_r.en_p, s_r.en_a, s_r.flag_p, s_r.flag_a};
        default: rd_mux = STM_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  // Pin drive; enable low while driving
  always_comb begin
    case (mode)
      STM_MODE_CMP: timer_output_pin = s_r.pin ^ s_r.ctrl1[STM_C1_INV];
      STM_MODE_PWM: timer_output_pin = pwm_level ^ s_r.ctrl1[STM_C1_INV];
      default: timer_output_pin = 1'b0;
    endcase
  end
  assign timer_output_pin_en = ~((mode == STM_MODE_CMP) || (mode == STM_MODE_PWM));
  assign irq_req = (s_r.flag_a & s_r.en_a) | (s_r.flag_p & s_r.en_p);

endmodule

//--- stm_pkg.sv
// Purpose: Shared constants and types for the standard timer block
// Assumes: Byte-wide registers on a plain strobe port
// Notes: Register offsets are word indices on the local port
package stm_pkg;
  localparam int STM_CNT_W = 10;
  localparam logic [2:0] STM_ADDR_CTRL0 = 3'h0;
  localparam logic [2:0] STM_ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] STM_ADDR_CNT_LO = 3'h2;
  localparam logic [2:0] STM_ADDR_CNT_HI = 3'h3;
  localparam logic [2:0] STM_ADDR_CMPA_LO = 3'h4;
  localparam logic [2:0] STM_ADDR_CMPA_HI = 3'h5;
  localparam logic [2:0] STM_ADDR_FLAGS = 3'h6;
  // Control 0 fields
  localparam int STM_C0_PAUSE = 7;
  localparam int STM_C0_CKSEL = 4;
  localparam int STM_C0_RUN = 3;
  localparam int STM_C0_PER = 0;
  // Control 1 fields
  localparam int STM_C1_MODE = 6;
  localparam int STM_C1_ACT = 4;
  localparam int STM_C1_INIT = 3;
  localparam int STM_C1_INV = 2;
  localparam int STM_C1_SWAP = 1;
  localparam int STM_C1_CLRSEL = 0;
  // Flags register fields
  localparam int STM_FL_A = 0;
  localparam int STM_FL_P = 1;
  localparam int STM_FL_AEN = 2;
  localparam int STM_FL_PEN = 3;
  localparam logic [7:0] STM_RST_BYTE = 8'h00;
  localparam logic [1:0] STM_MODE_CMP = 2'h0;
  localparam logic [1:0] STM_MODE_CAP = 2'h1;
  localparam logic [1:0] STM_MODE_PWM = 2'h2;
  localparam logic [1:0] STM_MODE_TMR = 2'h3;
  localparam logic [1:0] STM_ACT_NONE = 2'h0;
  localparam logic [1:0] STM_ACT_LOW = 2'h1;
  localparam logic [1:0] STM_ACT_HIGH = 2'h2;
  localparam logic [1:0] STM_ACT_TOG = 2'h3;
  localparam logic [2:0] STM_CK_DIV4 = 3'h0;
  localparam logic [2:0] STM_CK_SYS = 3'h1;
  localparam logic [2:0] STM_CK_DIV16 = 3'h2;
  localparam logic [2:0] STM_CK_DIV64 = 3'h3;
  localparam logic [2:0] STM_CK_BASE = 3'h4;
  localparam logic [2:0] STM_CK_PIN_R = 3'h6;
  localparam logic [2:0] STM_CK_PIN_F = 3'h7;
  localparam logic [5:0] STM_PRESC_RST = 6'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } stm_bus_req_t;

  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [STM_CNT_W-1:0] cmpa;
    logic [STM_CNT_W-1:0] cnt;
    logic flag_a;
    logic flag_p;
    logic en_a;
    logic en_p;
    logic run_d;
    logic pin;
    logic [5:0] presc;
    logic ck_s1;
    logic ck_s2;
    logic ck_d;
    logic [7:0] rdata;
  } stm_state_t;
endpackage

//--- stm_timer_props.sv
// Purpose: Port checker for the standard timer
// Assumes: Sees only top ports; mirrors control writes
// Notes: Bound to every timer instance
module stm_timer_props
  import stm_pkg::*;
#(
  parameter int CNT_W = STM_CNT_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic base_tick,
  input wire logic count_clk_pin,
  input wire logic timer_output_pin,
  input wire logic timer_output_pin_en,
  input wire logic irq_req
);
  logic [7:0] c0_r, c1_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      c0_r <= 8'h00;
      c1_r <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == 8'h00) c0_r <= reg_wdata;
      if (reg_wr && reg_addr == 8'h01) c1_r <= reg_wdata;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_wr_a; reg_wr && reg_addr == 8'h04; endsequence
  sequence s_rd_a; reg_rd && reg_addr == 8'h04; endsequence
  sequence s_run_on;
    reg_wr && reg_addr == 8'h00 && reg_wdata[3] && !c0_r[3] && c1_r[7:6] == 2'h0;
  endsequence
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  property p_hi_zero;
    reg_rd && (reg_addr == 8'h03 || reg_addr == 8'h05) |=> reg_rdata[7:2] == 6'h00;
  endproperty
  property p_ctrl_back; reg_rd && reg_addr == 8'h01 |=> reg_rdata == $past(c1_r); endproperty
  property p_cmpa_back; s_wr_a ##1 s_rd_a |=> reg_rdata == $past(reg_wdata, 2); endproperty
  property p_pin_en; timer_output_pin_en == c1_r[6]; endproperty
  property p_run_init;
    s_run_on |-> ##[1:3] timer_output_pin == (c1_r[3] ^ c1_r[2]);
  endproperty
  property p_pwm_force;
    c1_r[7:6] == 2'h2 && !c1_r[5] |-> timer_output_pin == ((c1_r[4] ~^ c1_r[3]) ^ c1_r[2]);
  endproperty
  property p_irq_off;
    reg_wr && reg_addr == 8'h06 && reg_wdata[3:2] == 2'h0 |=> ##[0:1] !irq_req;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_hi_zero: assert property (p_hi_zero) else $error("high byte spare bits set");
  a_ctrl_back: assert property (p_ctrl_back) else $error("mode readback wrong");
  a_cmpa_back: assert property (p_cmpa_back) else $error("compare A readback wrong");
  a_pin_en: assert property (p_pin_en) else $error("pin enable wrong for mode");
  a_run_init: assert property (p_run_init) else $error("pin not at initial level");
  a_pwm_force: assert property (p_pwm_force) else $error("forced pin level wrong");
  a_irq_off: assert property (p_irq_off) else $error("request with enables off");
endmodule
bind stm_timer stm_timer_props #(.CNT_W(CNT_W)) u_props (.*);

//--- tb.sv
// Purpose: Self-checking bench for the standard timer
// Assumes: 40 MHz clock, sync reset
// Notes: Count clock pins held idle
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [15:0] d, e;
  logic pin, pin_en, irq;
  int fails = 0, checks_done = 0, n;
  logic [23:0] rows [9] = '{24'h04A5A5, 24'h05FF03, 24'h02FF00, 24'h03FF00, 24'h07FF00,
    24'h019696, 24'h01C0C0, 24'h060C0C, 24'h060000};
  always #12.5 sys_clk = ~sys_clk;
  stm_timer u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .base_tick(1'b0), .count_clk_pin(1'b0), .timer_output_pin(pin),
    .timer_output_pin_en(pin_en), .irq_req(irq));
  task automatic results;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] x, y);
    checks_done++;
    if (y !== x) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", s, x, y);
    end
  endtask
  task automatic wr(input logic [7:0] a, w);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    q = {8'h00, reg_rdata};
    @(posedge sys_clk);
  endtask
  task automatic wrd(input logic [7:0] a, w, output logic [15:0] q);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    rd(a, q);
  endtask
  task automatic hi(output int k);
    k = 0;
    repeat (256) begin
      @(negedge sys_clk);
      k += (pin === 1'b1);
    end
    @(posedge sys_clk);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    results();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(8'(a), d);
      chk("reset", 16'h0000, d);
    end
    foreach (rows[i]) begin
      wrd(rows[i][23:16], rows[i][15:8], d);
      chk("row", {8'h00, rows[i][7:0]}, d);
    end
    // Compare mode, clear on A, toggle
    wr(8'h05, 8'h00);
    wr(8'h04, 8'h05);
    wr(8'h01, 8'h39);
    wr(8'h06, 8'h0C);
    wr(8'h00, 8'h58);
    @(negedge sys_clk);
    chk("init", 16'h0001, {15'h0000, pin});
    @(posedge sys_clk);
    wr(8'h00, 8'h18);
    n = 0;
    while (irq !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    chk("irq", 16'h0001, {15'h0000, irq});
    chk("toggle", 16'h0000, {15'h0000, pin});
    @(posedge sys_clk);
    wr(8'h00, 8'h10);
    rd(8'h06, d);
    chk("flags_a", 16'h000D, d);
    rd(8'h02, e);
    rd(8'h02, d);
    chk("hold", e, d);
    chk("clr_a", 16'h0001, {15'h0000, e <= 16'h0005});
    wr(8'h06, 8'h0D);
    rd(8'h06, d);
    chk("flag_clr", 16'h000C, d);
    // Compare mode, clear on period code 1
    wr(8'h01, 8'h38);
    wr(8'h00, 8'h19);
    repeat (140) @(posedge sys_clk);
    wr(8'h00, 8'h10);
    rd(8'h06, d);
    chk("flags_ap", 16'h000F, d);
    rd(8'h02, d);
    chk("per_clr", 16'h0001, {15'h0000, d < 16'h0080});
    wr(8'h06, 8'h0F);
    wr(8'h00, 8'h99);
    repeat (10) @(posedge sys_clk);
    rd(8'h02, d);
    chk("pause", 16'h0000, d);
    wr(8'h00, 8'h10);
    // PWM, period code 1, duty 32
    wr(8'h04, 8'h20);
    wr(8'h01, 8'hA8);
    wr(8'h00, 8'h19);
    repeat (8) @(posedge sys_clk);
    hi(n);
    chk("duty", 16'd64, 16'(n));
    wr(8'h04, 8'h80);
    repeat (130) @(posedge sys_clk);
    hi(n);
    chk("full", 16'd256, 16'(n));
    rd(8'h06, d);
    chk("pwm_flags", 16'h000F, d);
    wr(8'h01, 8'h9C);
    rd(8'h02, e);
    rd(8'h02, d);
    chk("runs", 16'h0001, {15'h0000, e !== d});
    results();
  end
endmodule
